// [verilog/clock_reset_status_unit.sv]
// clock security flag, reset source flags and main clock control
`timescale 1ns/100ps
`default_nettype none

module clock_reset_status_unit #(
  parameter bit ACTIVE_HALT_PRESENT = 1'b0
) (
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  input  wire clock_reset_status_pkg::reg_req_s    bus,
  output logic [7:0]                               rdata,
  input  wire logic                                main_clock_failed,
  input  wire logic                                security_option_enable,
  input  wire logic                                detector_option_enable,
  input  wire clock_reset_status_pkg::reset_cause_s reset_cause,
  input  wire logic                                halt_mode,
  input  wire logic                                active_halt_mode,
  input  wire logic                                wait_mode,
  input  wire logic                                core_irq_mask,
  output logic                                     safe_osc_select,
  output logic                                     irq_request,
  output logic [15:0]                              irq_vector,
  output logic                                     wait_wakeup,
  output logic                                     halt_wakeup,
  output logic                                     cpu_clock,
  output logic                                     cpu_tick,
  input  wire logic                                gpio_out,
  input  wire logic                                gpio_oe,
  output logic                                     clock_pin_out,
  output logic                                     clock_pin_oe
);

  clock_reset_status_pkg::status_state_s state;
  clock_reset_status_pkg::status_state_s next_state;
  logic                                  switch_event;
  logic                                  wr_status;
  logic                                  wr_misc;
  logic                                  rd_status;
  logic [7:0]                            status_byte;
  logic [7:0]                            misc_byte;
  logic                                  security_live;

  // clock security is off under the option byte and throughout HALT
  assign security_live = security_option_enable && !halt_mode;

  // safe oscillator follows the filtered failure level both ways
  assign safe_osc_select = security_live && state.fail_filt;
  assign switch_event    = safe_osc_select && !state.safe_prev;

  assign wr_status = bus.wr && (bus.addr == clock_reset_status_pkg::STATUS_ADDR);
  assign wr_misc   = bus.wr && (bus.addr == clock_reset_status_pkg::MISC_ADDR);
  assign rd_status = bus.rd && (bus.addr == clock_reset_status_pkg::STATUS_ADDR);

  always_comb begin
    status_byte = clock_reset_status_pkg::READ_ZERO;
    status_byte[clock_reset_status_pkg::ST_WDG_BIT]    = state.wdg_flag;
    status_byte[clock_reset_status_pkg::ST_DETECT_BIT] = state.detect && security_option_enable;
    status_byte[clock_reset_status_pkg::ST_IRQEN_BIT]  = state.irq_en;
    // undefined when the detector is off: the stored value is shown as is
    status_byte[clock_reset_status_pkg::ST_UV_BIT]     = state.uv_flag;
    misc_byte = clock_reset_status_pkg::READ_ZERO;
    misc_byte[clock_reset_status_pkg::MC_DIV_LO_BIT] = state.div_sel[0];
    misc_byte[clock_reset_status_pkg::MC_DIV_HI_BIT] = state.div_sel[1];
    misc_byte[clock_reset_status_pkg::MC_SLOW_BIT]   = state.slow;
    misc_byte[clock_reset_status_pkg::MC_CKOUT_BIT]  = state.ckout_en;
  end

  always_comb begin
    next_state = state;
    // pin synchroniser; level moves once stages two and three agree
    next_state.fail_sync = {state.fail_sync[1:0], main_clock_failed};
    if (state.fail_sync[1] == state.fail_sync[2]) begin
      next_state.fail_filt = state.fail_sync[2];
    end
    next_state.safe_prev = safe_osc_select;

    if (!rst_n) begin
      next_state.fail_sync = '0;
      next_state.fail_filt = 1'b0;
      next_state.safe_prev = 1'b0;
      next_state.detect    = 1'b0;
      next_state.irq_en    = 1'b0;
      next_state.div_sel   = clock_reset_status_pkg::DIV_SEL_RESET;
      next_state.slow      = 1'b0;
      next_state.ckout_en  = 1'b0;
      next_state.rdata     = clock_reset_status_pkg::READ_ZERO;
      if (reset_cause.from_undervoltage) begin
        next_state.uv_flag  = 1'b1;
        next_state.wdg_flag = 1'b0;
      end else if (reset_cause.from_watchdog) begin
        next_state.wdg_flag = 1'b1;
        // undervoltage record kept across later resets
        next_state.uv_flag  = state.uv_flag;
      end
    end else if (halt_mode) begin
      // register frozen, configuration held for interrupt exit
      next_state.safe_prev = 1'b0;
    end else begin
      if (bus.rd) begin
        unique case (bus.addr)
          clock_reset_status_pkg::STATUS_ADDR: next_state.rdata = status_byte;
          clock_reset_status_pkg::MISC_ADDR:   next_state.rdata = misc_byte;
          default:                             next_state.rdata = clock_reset_status_pkg::READ_ZERO;
        endcase
      end
      // read clears only after the original oscillator is back
      if (rd_status && !state.fail_filt) begin
        next_state.detect = 1'b0;
      end
      // a switch in the clearing cycle still sets the flag
      if (switch_event) begin
        next_state.detect = 1'b1;
      end
      if (!security_option_enable) begin
        next_state.detect = 1'b0;
      end
      if (wr_status) begin
        next_state.irq_en = bus.wdata[clock_reset_status_pkg::ST_IRQEN_BIT];
        if (!bus.wdata[clock_reset_status_pkg::ST_UV_BIT]) begin
          next_state.uv_flag = 1'b0;
        end
        if (!bus.wdata[clock_reset_status_pkg::ST_WDG_BIT]) begin
          next_state.wdg_flag = 1'b0;
        end
      end
      if (wr_misc) begin
        next_state.div_sel[0] = bus.wdata[clock_reset_status_pkg::MC_DIV_LO_BIT];
        next_state.div_sel[1] = bus.wdata[clock_reset_status_pkg::MC_DIV_HI_BIT];
        next_state.slow       = bus.wdata[clock_reset_status_pkg::MC_SLOW_BIT];
        next_state.ckout_en   = bus.wdata[clock_reset_status_pkg::MC_CKOUT_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign rdata = state.rdata;

  // enable is inert while clock security is disabled
  assign irq_request = security_option_enable && state.detect && state.irq_en
                       && !core_irq_mask;
  assign irq_vector  = clock_reset_status_pkg::SAFE_VECTOR;
  // core forces its mask clear in WAIT, so the request itself wakes it
  assign wait_wakeup = wait_mode && irq_request;
  assign halt_wakeup = ACTIVE_HALT_PRESENT && active_halt_mode && irq_request;

  cpu_clock_prescaler u_prescaler (
    .clk       (clk),
    .rst_n     (rst_n),
    .div_sel   (state.div_sel),
    .slow      (state.slow),
    .cpu_clock (cpu_clock),
    .cpu_tick  (cpu_tick)
  );

  // dedicated pin: cpu clock when enabled, plain port line otherwise
  assign clock_pin_out = state.ckout_en ? cpu_clock : gpio_out;
  assign clock_pin_oe  = state.ckout_en ? 1'b1 : gpio_oe;

  // assertions

  sequence s_switch;
    !halt_mode && security_option_enable && safe_osc_select && !state.safe_prev;
  endsequence

  sequence s_halted_two;
    halt_mode ##1 halt_mode;
  endsequence

  property p_detect_set;
    @(posedge clk) disable iff (!rst_n)
      s_switch |=> state.detect;
  endproperty
  a_detect_set: assert property (p_detect_set) else $error("switch did not set detect");

  property p_irq_cause;
    @(posedge clk) disable iff (!rst_n)
      irq_request |-> status_byte[clock_reset_status_pkg::ST_DETECT_BIT] && state.irq_en
                      && !core_irq_mask;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");

  property p_wait_wake;
    @(posedge clk) disable iff (!rst_n)
      wait_mode && state.detect && state.irq_en && security_option_enable && !core_irq_mask
      |-> wait_wakeup;
  endproperty
  a_wait_wake: assert property (p_wait_wake) else $error("wait not left on interrupt");

  property p_halt_frozen;
    @(posedge clk) disable iff (!rst_n)
      s_halted_two |-> $stable(status_byte) && !safe_osc_select;
  endproperty
  a_halt_frozen: assert property (p_halt_frozen) else $error("status changed in halt");

  property p_reset_values;
    @(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> !state.irq_en && !state.detect && !state.slow && !state.ckout_en;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad value after reset");

  property p_no_halt_wake;
    @(posedge clk) disable iff (!rst_n)
      !active_halt_mode |-> !halt_wakeup;
  endproperty
  a_no_halt_wake: assert property (p_no_halt_wake) else $error("woke from plain halt");

  property p_read_clear;
    @(posedge clk) disable iff (!rst_n)
      rd_status && !halt_mode && !state.fail_filt && !switch_event |=> !state.detect;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear detect");

  property p_security_off;
    @(posedge clk) disable iff (!rst_n)
      !security_option_enable |-> !status_byte[clock_reset_status_pkg::ST_DETECT_BIT]
                                  && !irq_request && !safe_osc_select;
  endproperty
  a_security_off: assert property (p_security_off) else $error("detect seen with security off");

  property p_uv_clear;
    @(posedge clk) disable iff (!rst_n)
      wr_status && !halt_mode && !bus.wdata[clock_reset_status_pkg::ST_UV_BIT]
      |=> !status_byte[clock_reset_status_pkg::ST_UV_BIT];
  endproperty
  a_uv_clear: assert property (p_uv_clear) else $error("undervoltage flag not cleared");

  property p_uv_sticky;
    @(posedge clk) disable iff (!rst_n)
      state.uv_flag && !wr_status |=> state.uv_flag;
  endproperty
  a_uv_sticky: assert property (p_uv_sticky) else $error("undervoltage flag lost");

  property p_uv_kept;
    @(posedge clk) disable iff (!rst_n)
      !detector_option_enable && !wr_status
      |=> $stable(status_byte[clock_reset_status_pkg::ST_UV_BIT]);
  endproperty
  a_uv_kept: assert property (p_uv_kept) else $error("undervoltage flag moved");

  property p_wdg_clear;
    @(posedge clk) disable iff (!rst_n)
      wr_status && !halt_mode && !bus.wdata[clock_reset_status_pkg::ST_WDG_BIT]
      |=> !status_byte[clock_reset_status_pkg::ST_WDG_BIT];
  endproperty
  a_wdg_clear: assert property (p_wdg_clear) else $error("watchdog flag not cleared");

  property p_read_data;
    @(posedge clk) disable iff (!rst_n)
      rd_status && !halt_mode |=> rdata == $past(status_byte);
  endproperty
  a_read_data: assert property (p_read_data) else $error("status read data wrong");

  property p_clock_out;
    @(posedge clk) disable iff (!rst_n)
      state.ckout_en |-> clock_pin_oe && (clock_pin_out == cpu_clock);
  endproperty
  a_clock_out: assert property (p_clock_out) else $error("clock not on pin");

  property p_pin_plain;
    @(posedge clk) disable iff (!rst_n)
      !state.ckout_en |-> (clock_pin_oe == gpio_oe) && (clock_pin_out == gpio_out);
  endproperty
  a_pin_plain: assert property (p_pin_plain) else $error("pin not plain io");

  property p_normal_divide;
    @(posedge clk) disable iff (!rst_n)
      !state.slow && !$past(state.slow) && cpu_tick
      && !(wr_misc && bus.wdata[clock_reset_status_pkg::MC_SLOW_BIT])
      |=> !cpu_tick ##1 cpu_tick;
  endproperty
  a_normal_divide: assert property (p_normal_divide) else $error("normal divide not 2");

endmodule : clock_reset_status_unit

`default_nettype wire

// [include/clock_reset_status_pkg.sv]
// constants and types of the clock, reset and supply status unit
package clock_reset_status_pkg;

  localparam logic [7:0]  STATUS_ADDR   = 8'h25;
  localparam logic [7:0]  MISC_ADDR     = 8'h20;
  localparam logic [15:0] SAFE_VECTOR   = 16'hFFF6;

  // status register fields
  localparam int unsigned ST_WDG_BIT    = 0;
  localparam int unsigned ST_DETECT_BIT = 1;
  localparam int unsigned ST_IRQEN_BIT  = 2;
  localparam int unsigned ST_UV_BIT     = 4;

  // misc control fields
  localparam int unsigned MC_DIV_LO_BIT = 0;
  localparam int unsigned MC_DIV_HI_BIT = 1;
  localparam int unsigned MC_SLOW_BIT   = 2;
  localparam int unsigned MC_CKOUT_BIT  = 3;

  localparam logic [1:0]  DIV_SEL_RESET = 2'h0;
  localparam logic [7:0]  READ_ZERO     = 8'h00;

  // prescaler half periods in oscillator cycles
  localparam logic [4:0]  NORMAL_HALF   = 5'h01;
  localparam logic [4:0]  SLOW_HALF_MIN = 5'h02;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  typedef struct packed {
    logic       from_undervoltage;
    logic       from_watchdog;
  } reset_cause_s;

  typedef struct packed {
    logic [2:0] fail_sync;
    logic       fail_filt;
    logic       safe_prev;
    logic       detect;
    logic       irq_en;
    logic       uv_flag;
    logic       wdg_flag;
    logic [1:0] div_sel;
    logic       slow;
    logic       ckout_en;
    logic [7:0] rdata;
  } status_state_s;

  typedef struct packed {
    logic [4:0] count;
    logic       level;
    logic       tick;
  } prescaler_state_s;

endpackage : clock_reset_status_pkg

// [verilog/cpu_clock_prescaler.sv]
// cpu clock prescaler: oscillator divided by 2, or 4 to 32 in slow mode
`timescale 1ns/100ps
`default_nettype none

module cpu_clock_prescaler (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] div_sel,
  input  wire logic       slow,
  output logic            cpu_clock,
  output logic            cpu_tick
);

  clock_reset_status_pkg::prescaler_state_s state;
  clock_reset_status_pkg::prescaler_state_s next_state;
  logic [4:0]                               half;

  always_comb begin
    // half period: 1 normal, 2/4/8/16 slow
    half = slow ? 5'(clock_reset_status_pkg::SLOW_HALF_MIN << div_sel)
                : clock_reset_status_pkg::NORMAL_HALF;
    next_state = state;
    next_state.tick = 1'b0;
    if (!rst_n) begin
      next_state.count = '0;
      next_state.level = 1'b0;
    end else if (state.count >= 5'(half - 5'h01)) begin
      next_state.count = '0;
      next_state.level = ~state.level;
      next_state.tick  = ~state.level;
    end else begin
      next_state.count = 5'(state.count + 5'h01);
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign cpu_clock = state.level;
  assign cpu_tick  = state.tick;

endmodule : cpu_clock_prescaler

`default_nettype wire

// [testbench/clock_reset_status_unit_bench.sv]
// self-checking bench of the clock, reset and supply status unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module clock_reset_status_unit_bench;
  logic                                 clk = 1'b0;
  logic                                 rst_n = 1'b0;
  clock_reset_status_pkg::reg_req_s     bus = '0;
  clock_reset_status_pkg::reset_cause_s cause = 2'h2;
  logic [7:0]                           rdata;
  logic                                 fail = 1'b0;
  logic                                 sec_on = 1'b1;
  logic                                 uv_on = 1'b1;
  logic                                 halt = 1'b0;
  logic                                 waitm = 1'b0;
  logic                                 imask = 1'b0;
  logic                                 gout = 1'b0;
  logic                                 goe = 1'b0;
  logic                                 safe_sel, irq, wwake, hwake, cpu_clock, cpu_tick;
  logic                                 pin_out, pin_oe;
  logic [15:0]                          vec;
  int                                   miscompares = 0;
  int                                   checked = 0;
  int                                   cycles = 0;
  int                                   uvf, wdg, ien, det, n;
  logic [31:0]                          lfsr = 32'hAAFDD034;
  logic [7:0]                           d, r;
  logic [1:0]                           causes [4] = '{2'h2, 2'h1, 2'h0, 2'h1};

  clock_reset_status_unit #(.ACTIVE_HALT_PRESENT(1'b0)) u_dut (
    .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .main_clock_failed(fail),
    .security_option_enable(sec_on), .detector_option_enable(uv_on), .reset_cause(cause),
    .halt_mode(halt), .active_halt_mode(1'b0), .wait_mode(waitm), .core_irq_mask(imask),
    .safe_osc_select(safe_sel), .irq_request(irq), .irq_vector(vec), .wait_wakeup(wwake),
    .halt_wakeup(hwake), .cpu_clock(cpu_clock), .cpu_tick(cpu_tick), .gpio_out(gout),
    .gpio_oe(goe), .clock_pin_out(pin_out), .clock_pin_oe(pin_oe)
  );

  always #10 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand

  function automatic logic [7:0] status_exp();
    return {3'h0, uvf[0], 1'b0, ien[0], det[0], wdg[0]};
  endfunction : status_exp

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    r = rdata;
  endtask : rd

  task automatic do_reset(input logic [1:0] c);
    @(posedge clk);
    cause <= c;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    if (c[1]) begin
      uvf = 1;
      wdg = 0;
    end else if (c[0]) begin
      wdg = 1;
    end
    ien = 0;
    det = 0;
  endtask : do_reset

  task automatic wait_sel(input logic lvl);
    n = 0;
    while (safe_sel !== lvl && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(safe_sel, lvl)
  endtask : wait_sel

  // first read after recovery shows the flag, the second sees it cleared
  task automatic recover();
    @(posedge clk);
    fail <= 1'b0;
    wait_sel(1'b0);
    rd(clock_reset_status_pkg::STATUS_ADDR);
    `CHK(r, status_exp())
    det = 0;
    rd(clock_reset_status_pkg::STATUS_ADDR);
    `CHK(r, status_exp())
  endtask : recover

  task automatic tick_gap();
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (cpu_tick !== 1'b1 && n < 100);
  endtask : tick_gap

  task automatic test_done();
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    uvf = 1; wdg = 0; ien = 0; det = 0;
    rd(clock_reset_status_pkg::STATUS_ADDR);
    `CHK(r, status_exp())
    `CHK(vec, 16'hFFF6)
    rd(8'h30);
    `CHK(r, 8'h00)
    for (int i = 0; i < 6; i++) begin
      lfsr = next_rand(lfsr);
      d = lfsr[7:0];
      wr(clock_reset_status_pkg::STATUS_ADDR, d);
      if (!d[4]) uvf = 0;
      if (!d[0]) wdg = 0;
      ien = d[2];
      rd(clock_reset_status_pkg::STATUS_ADDR);
      `CHK(r, status_exp())
    end
    for (int i = 0; i < 4; i++) begin
      do_reset(causes[i]);
      rd(clock_reset_status_pkg::STATUS_ADDR);
      `CHK(r, status_exp())
    end
    wr(clock_reset_status_pkg::STATUS_ADDR, 8'h04);
    uvf = 0; wdg = 0; ien = 1;
    rd(clock_reset_status_pkg::STATUS_ADDR);
    `CHK(r, status_exp())
    // failure with interrupt enabled, then mask and wait wakeup
    @(posedge clk);
    fail <= 1'b1;
    wait_sel(1'b1);
    @(posedge clk);
    #1;
    det = 1;
    `CHK(irq, 1'b1)
    @(posedge clk);
    imask <= 1'b1;
    waitm <= 1'b1;
    @(posedge clk);
    #1;
    `CHK({irq, wwake}, 2'h0)
    @(posedge clk);
    imask <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(wwake, 1'b1)
    @(posedge clk);
    waitm <= 1'b0;
    rd(clock_reset_status_pkg::STATUS_ADDR);
    `CHK(r, status_exp())
    rd(clock_reset_status_pkg::STATUS_ADDR);
    `CHK(r, status_exp())
    recover();
    // halt: no detection, accesses ignored, configuration kept
    @(posedge clk);
    halt <= 1'b1;
    fail <= 1'b1;
    wr(clock_reset_status_pkg::STATUS_ADDR, 8'h00);
    repeat (6) @(posedge clk);
    #1;
    `CHK({safe_sel, irq, hwake}, 3'h0)
    @(posedge clk);
    halt <= 1'b0;
    wait_sel(1'b1);
    repeat (2) @(posedge clk);
    #1;
    det = 1;
    `CHK({irq, hwake}, 2'h2)
    recover();
    // clock security disabled by option
    @(posedge clk);
    sec_on <= 1'b0;
    uv_on <= 1'b0;
    fail <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    `CHK({safe_sel, irq}, 2'h0)
    rd(clock_reset_status_pkg::STATUS_ADDR);
    `CHK(r, status_exp())
    @(posedge clk);
    fail <= 1'b0;
    // failure gone before security returns, so no late switch event
    repeat (8) @(posedge clk);
    sec_on <= 1'b1;
    uv_on <= 1'b1;
    repeat (2) @(posedge clk);
    // prescaler rates and clock output pin
    for (int i = 0; i < 5; i++) begin
      lfsr = next_rand(lfsr);
      d = {4'h0, lfsr[0], (i < 4), i[1:0]};
      wr(clock_reset_status_pkg::MISC_ADDR, d);
      gout <= lfsr[1];
      goe <= lfsr[2];
      rd(clock_reset_status_pkg::MISC_ADDR);
      `CHK(r & 8'h0F, d)
      tick_gap();
      tick_gap();
      `CHK(n, (i < 4) ? (4 << i) : 2)
      `CHK({pin_out, pin_oe}, d[3] ? {cpu_clock, 1'b1} : {gout, goe})
    end
    test_done();
  end
endmodule : clock_reset_status_unit_bench

`default_nettype wire
